/* File: dv/ascr_ctrl_model.sv */
`default_nettype none
module ascr_ctrl_model (
  // Clock used only to pace the pins
  input wire logic core_clk,
  // Three-wire configuration pins toward the block
  output var ascr_pkg::ascr_serial_s serialOut,
  input wire logic readbackPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Six clocks per phase, well above the two-clock sync minimum
  localparam int HalfClocks = 6;

  // Idle: enable high, serial clock parked low
  initial begin
    serialOut = '{sen: 1'b1, sclk: 1'b0, sdata: 1'b1};
  end

  // One 16-bit word, MSB first; the pin is latched just before each data-phase fall
  task automatic frame(input logic [15:0] word, output logic [7:0] seen);
    seen = 8'h00;
    serialOut.sen = 1'b0;
    repeat (HalfClocks) @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      serialOut.sclk = 1'b1;
      serialOut.sdata = word[i];
      repeat (HalfClocks) @(negedge core_clk);
      if (i < 8) begin
        seen = {seen[6:0], readbackPin};
      end
      serialOut.sclk = 1'b0;
      repeat (HalfClocks) @(negedge core_clk);
    end
    serialOut.sen = 1'b1;
    // No pull on the data line, so show the inverse once released
    serialOut.sdata = ~serialOut.sdata;
    repeat (2 * HalfClocks) @(negedge core_clk);
  endtask

  // Register write; illegal codes are steered to legal ones, as a real controller must
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    if (addr == ascr_pkg::ADDR_PERF_ONE && (data[1:0] == 2'h1 || data[1:0] == 2'h2)) begin
      data[1:0] = 2'h3;
    end
    if (addr == ascr_pkg::ADDR_GAIN_PATTERN && data[7:4] > ascr_pkg::GAIN_MAX_CODE) begin
      data[7:4] = ascr_pkg::GAIN_MAX_CODE;
    end
    frame({addr, data}, unused);
  endtask

  // Register read; readback must already be on
  // A read of address zero also writes it, so its data byte keeps readback on
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    frame({addr, (addr == ascr_pkg::ADDR_RESET_READBACK) ? 8'h01 : 8'h00}, data);
  endtask

  // Both performance boosts on for best results
  task automatic enable_best_perf();
    write_reg(ascr_pkg::ADDR_PERF_ONE, 8'h03);
    write_reg(ascr_pkg::ADDR_PERF_TWO, 8'h01);
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  ascr_pkg::ascr_serial_s serialIn;
  logic pin;
  logic sampleValid = 1'b0;
  logic [13:0] convData = 14'h0000;
  logic overRange = 1'b0;
  logic outValid;
  logic [13:0] outData;
  ascr_pkg::ascr_cfg_s cfg;
  logic [11:0] narrowOut;
  int n_mismatch = 0;
  int n_checks = 0;

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;

  ascr_top #(.DataWidth(14)) ascr_top_inst (
    .core_clk(core_clk), .rstn(rstn), .serialIn(serialIn), .overrangeOrReadbackPin(pin),
    .sampleValid(sampleValid), .convData(convData), .overRange(overRange),
    .outValid(outValid), .outData(outData), .cfg(cfg));

  ascr_ctrl_model ascr_ctrl_model_inst (.core_clk(core_clk), .serialOut(serialIn), .readbackPin(pin));

  // Narrow variant on the same pins, to see the slower ramp
  if (1) begin : g_narrow
    ascr_top #(.DataWidth(12)) ascr_top_inst (
      .core_clk(core_clk), .rstn(rstn), .serialIn(serialIn), .overrangeOrReadbackPin(),
      .sampleValid(sampleValid), .convData(convData[11:0]), .overRange(overRange),
      .outValid(), .outData(narrowOut), .cfg());
  end

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sampleValid = 1'b0; // No samples while a frame runs, so patterns start clean
    ascr_ctrl_model_inst.write_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    ascr_ctrl_model_inst.read_reg(a, got);
    check($sformatf("reg %h", a), exp, got);
  endtask

  // One sample in, result judged one cycle later; valid stays up for back-to-back use
  task automatic sample(input logic [13:0] conv, input logic [13:0] exp, input string what);
    sampleValid = 1'b1;
    convData = conv;
    @(negedge core_clk);
    check("outValid", 1, outValid);
    check(what, exp, outData);
  endtask

  task automatic idle();
    sampleValid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic t_reset_state();
    check("cfg after reset", 0, cfg);
    overRange = 1'b1;
    @(negedge core_clk);
    check("pin as over-range high", 1, pin);
    overRange = 1'b0;
    @(negedge core_clk);
    check("pin as over-range low", 0, pin);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h01);
    for (int i = 0; i < ascr_pkg::ASCR_NUM_REGS; i++) begin
      rd_chk(ascr_pkg::REG_ADDR[i], 8'h00);
    end
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h00);
    $display("t_reset_state done");
  endtask

  task automatic t_write_fields();
    ascr_ctrl_model_inst.enable_best_perf();
    check("boost one", 2'h3, cfg.performanceBoostOne);
    check("boost two", 1, cfg.performanceBoostTwo);
    for (int i = 1; i < ascr_pkg::ASCR_NUM_REGS; i++) begin
      wr(ascr_pkg::REG_ADDR[i], 8'h5f);
    end
    check("clock drive level", 1, cfg.clockDriverDriveLevel);
    check("data drive level", 1, cfg.dataDriveLevel);
    check("swing from one write", 6'h17, cfg.swingCode);
    check("digital path", 1, cfg.digitalPathEnable);
    check("format field", 8'h5f & ascr_pkg::WRITE_MASK[ascr_pkg::IDX_FMT], cfg.formatOffset);
    check("standby", 1, cfg.standby);
    check("global power-down", 1, cfg.powerDownGlobal);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h01);
    for (int i = 1; i < ascr_pkg::ASCR_NUM_REGS; i++) begin
      rd_chk(ascr_pkg::REG_ADDR[i], 8'h5f & ascr_pkg::WRITE_MASK[i]);
    end
    // Writes other than to the control register are refused during readback
    wr(ascr_pkg::ADDR_DRIVER_STRENGTH, 8'h00);
    rd_chk(ascr_pkg::ADDR_DRIVER_STRENGTH, 8'h03);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h00);
    $display("t_write_fields done");
  endtask

  task automatic t_swing();
    logic [5:0] codes [6];
    codes = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f};
    foreach (codes[k]) begin
      wr(ascr_pkg::ADDR_PDN_SWING_EN, 8'h00);
      wr(ascr_pkg::ADDR_SWING_CODE, {codes[k], 2'b00});
      check("swing gated off", 0, cfg.swingCode);
      wr(ascr_pkg::ADDR_PDN_SWING_EN, 8'h03);
      check("swing code", codes[k], cfg.swingCode);
    end
    $display("t_swing done");
  endtask

  task automatic t_patterns();
    logic [13:0] first;
    wr(ascr_pkg::ADDR_CLK_LAT_STBY, 8'h08);
    wr(ascr_pkg::ADDR_USER_HIGH, 8'hab);
    wr(ascr_pkg::ADDR_USER_LOW, 8'hcc);
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h00);
    sample(14'h0123, 14'h0123, "normal data");
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h01);
    sample(14'h0123, 14'h0000, "all zeros");
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h02);
    sample(14'h0123, 14'h3fff, "all ones");
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h05);
    sample(14'h0123, {8'hab, 6'h33}, "user word");
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h03);
    sample(14'h0123, 14'h1555, "toggle first");
    first = outData;
    sample(14'h0123, 14'h2aaa, "toggle second");
    check("toggle word", 1, first === 14'h1555 || first === 14'h2aaa);
    idle();
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h04);
    // Run past the top code to see the wrap back to zero
    for (int k = 0; k < 16390; k++) begin
      sample(14'h0123, k[13:0], "ramp");
      check("ramp 12-bit", (k / 4) % 4096, narrowOut);
    end
    idle();
    wr(ascr_pkg::ADDR_CLK_LAT_STBY, 8'h00);
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'h01);
    sample(14'h0123, 14'h0123, "low latency bypass");
    idle();
    $display("t_patterns done");
  endtask

  task automatic t_gain();
    int codes [3];
    codes = '{0, 6, 12};
    wr(ascr_pkg::ADDR_CLK_LAT_STBY, 8'h08);
    foreach (codes[k]) begin
      wr(ascr_pkg::ADDR_GAIN_PATTERN, {codes[k][3:0], 4'h0});
      sample(14'h1000, ascr_pkg::GAIN_Q12[codes[k]], "gain");
      idle();
    end
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'hc8);
    sample(14'h1000, 14'h1000, "gain bypassed");
    idle();
    wr(ascr_pkg::ADDR_GAIN_PATTERN, 8'hc0);
    wr(ascr_pkg::ADDR_CLK_LAT_STBY, 8'h00);
    sample(14'h1000, 14'h1000, "gain in low latency");
    idle();
    $display("t_gain done");
  endtask

  task automatic t_soft_reset();
    wr(ascr_pkg::ADDR_DRIVER_STRENGTH, 8'h03);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h02);
    check("cfg after soft reset", 0, cfg);
    // A stuck reset bit would keep wiping this write
    wr(ascr_pkg::ADDR_DRIVER_STRENGTH, 8'h02);
    check("write after soft reset", 1, cfg.clockDriverDriveLevel);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h01);
    rd_chk(ascr_pkg::ADDR_GAIN_PATTERN, 8'h00);
    wr(ascr_pkg::ADDR_RESET_READBACK, 8'h00);
    $display("t_soft_reset done");
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset_state();
    t_write_fields();
    t_swing();
    t_patterns();
    t_gain();
    t_soft_reset();
    tally_and_finish();
  end

  // Guard against a hung run
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    $display("[FAIL] run length expected under 90000 cycles seen timeout");
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* File: rtl/ascr_pkg.sv */
`default_nettype none
package ascr_pkg;
  localparam int ASCR_NUM_REGS = 15;
  localparam int ASCR_MAX_W = 14;

  // Register offsets on the serial port
  localparam logic [7:0] ADDR_RESET_READBACK = 8'h00;
  localparam logic [7:0] ADDR_SWING_CODE = 8'h01;
  localparam logic [7:0] ADDR_PERF_ONE = 8'h03;
  localparam logic [7:0] ADDR_GAIN_PATTERN = 8'h25;
  localparam logic [7:0] ADDR_DRIVER_STRENGTH = 8'h26;
  localparam logic [7:0] ADDR_FORMAT_OFFSET = 8'h3d;
  localparam logic [7:0] ADDR_USER_HIGH = 8'h3f;
  localparam logic [7:0] ADDR_USER_LOW = 8'h40;
  localparam logic [7:0] ADDR_IFC_CLK_EDGE = 8'h41;
  localparam logic [7:0] ADDR_CLK_LAT_STBY = 8'h42;
  localparam logic [7:0] ADDR_PDN_SWING_EN = 8'h43;
  localparam logic [7:0] ADDR_PERF_TWO = 8'h4a;
  localparam logic [7:0] ADDR_PEDESTAL = 8'hbf;
  localparam logic [7:0] ADDR_OFFSET_LOOP = 8'hcf;
  localparam logic [7:0] ADDR_SLOW_CLOCK = 8'hdb;
  localparam logic [14:0][7:0] REG_ADDR = {ADDR_SLOW_CLOCK, ADDR_OFFSET_LOOP, ADDR_PEDESTAL, ADDR_PERF_TWO,
    ADDR_PDN_SWING_EN, ADDR_CLK_LAT_STBY, ADDR_IFC_CLK_EDGE, ADDR_USER_LOW, ADDR_USER_HIGH, ADDR_FORMAT_OFFSET,
    ADDR_DRIVER_STRENGTH, ADDR_GAIN_PATTERN, ADDR_PERF_ONE, ADDR_SWING_CODE, ADDR_RESET_READBACK};

  // Position of each register in the bank
  localparam int IDX_CTRL = 0;
  localparam int IDX_SWING = 1;
  localparam int IDX_PERF1 = 2;
  localparam int IDX_GAIN = 3;
  localparam int IDX_DRV = 4;
  localparam int IDX_FMT = 5;
  localparam int IDX_UPH = 6;
  localparam int IDX_UPL = 7;
  localparam int IDX_IFC = 8;
  localparam int IDX_CLKLAT = 9;
  localparam int IDX_PDN = 10;
  localparam int IDX_PERF2 = 11;
  localparam int IDX_PED = 12;
  localparam int IDX_OFSLOOP = 13;
  localparam int IDX_SLOW = 14;

  // Writable bits; fixed-zero bits are never stored
  localparam logic [14:0][7:0] WRITE_MASK = {8'h01, 8'hbc, 8'hfc, 8'h01, 8'h53, 8'hcc, 8'hff, 8'hfc, 8'hff,
    8'he0, 8'h03, 8'hff, 8'h03, 8'hfc, 8'h03};
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // Field positions
  localparam int SW_RESET_BIT = 1;
  localparam int READBACK_BIT = 0;
  localparam int SWING_LSB = 2;
  localparam int GAIN_LSB = 4;
  localparam int GAIN_BYPASS_BIT = 3;
  localparam int PATTERN_LSB = 0;
  localparam int CLK_DRIVE_BIT = 1;
  localparam int DATA_DRIVE_BIT = 0;
  localparam int DIGPATH_BIT = 3;
  localparam int STANDBY_BIT = 2;
  localparam int PDN_GLOBAL_BIT = 6;
  localparam int PDN_OBUF_BIT = 4;
  localparam int SWING_EN_LSB = 0;

  // Serial frame counts
  localparam logic [4:0] LAST_ADDR_BIT = 5'h07;
  localparam logic [4:0] LAST_FRAME_BIT = 5'h0f;

  // Gain in Q12, half-decibel steps
  localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
  localparam int GAIN_FRAC_BITS = 12;
  localparam logic [12:0][13:0] GAIN_Q12 = {14'h1fed, 14'h1e26, 14'h1c78, 14'h1adf, 14'h195e, 14'h17f3,
    14'h169c, 14'h1558, 14'h1425, 14'h1305, 14'h11f4, 14'h10f3, 14'h1000};
  localparam logic [13:0] ALT_WORD = 14'h1555;

  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_ZEROS = 3'h1,
    PAT_ONES = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP = 3'h4,
    PAT_USER = 3'h5
  } ascr_pattern_e;

  typedef struct packed {
    logic sen;
    logic sclk;
    logic sdata;
  } ascr_serial_s;

  typedef struct packed {
    logic [5:0] swingCode;
    logic [1:0] performanceBoostOne;
    logic performanceBoostTwo;
    logic clockDriverDriveLevel;
    logic dataDriveLevel;
    logic digitalPathEnable;
    logic standby;
    logic powerDownGlobal;
    logic powerDownOutBuf;
    logic [7:0] formatOffset;
    logic [7:0] ifcClkEdge;
    logic [1:0] clkFallCtrl;
    logic [5:0] offsetPedestal;
    logic [7:0] offsetLoop;
    logic lowSpeed;
  } ascr_cfg_s;

  typedef struct packed {
    logic [2:0] senSync;
    logic [2:0] sclkSync;
    logic [2:0] sdataSync;
    logic senF;
    logic sclkF;
    logic [4:0] bitCount;
    logic [15:0] shiftIn;
    logic [7:0] readShift;
    logic readbackBit;
    logic [14:0][7:0] regs;
    logic swResetPend;
    logic [13:0] dataOut;
    logic dataValid;
    logic togglePhase;
    logic [13:0] rampCount;
    logic [1:0] rampDiv;
    logic pinOut;
  } ascr_state_s;
endpackage
`default_nettype wire

/* File: rtl/ascr_top.sv */
// Notes on behaviour
// - Writing one to the reset bit clears all registers; the bit self-clears.
// - Readback off: pin shows over-range; readback on: pin shifts register contents.
// - Six-bit swing code in register 0x01 bits 7..2 selects output swing.
// - Swing code applies only while both swing enable bits are set.
// - Gain field bits 7..4 of 0x25 sets gain, 0.5dB steps, 0 to 6dB.
// - Gain applies only with bypass clear and digital path enabled.
// - Pattern 000 normal data, 001 all zeros, 010 all ones.
// - Pattern 011 alternates 0101 word and its complement every sample.
// - Pattern 100 on 14-bit: ramp steps every sample, 0 to 16383.
// - On 12-bit: ramp steps every fourth sample, 0 to 4095.
// - Pattern 101 outputs user word from 0x3F/0x40; 110/111 unused.
// - One write sets every field of a register at once.
// - All registers are zero after reset; fixed-zero bits stay zero.
// - Register 0x26 bit 1 sets clock driver strength, bit 0 data drivers.
// - Digital path disabled means low latency: gain and patterns bypassed.
`default_nettype none
module ascr_top #(
  parameter int DataWidth = 14
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial configuration pins
  input wire ascr_pkg::ascr_serial_s serialIn,
  output logic overrangeOrReadbackPin,
  // Converter samples in
  input wire logic sampleValid,
  input wire logic [DataWidth-1:0] convData,
  input wire logic overRange,
  // Processed samples out
  output logic outValid,
  output logic [DataWidth-1:0] outData,
  // Configuration toward analog and output stages
  output ascr_pkg::ascr_cfg_s cfg
);
  localparam logic [1:0] RampDivLast = (DataWidth == 12) ? 2'h3 : 2'h0;
  localparam logic [13:0] RampMax = 14'((1 << DataWidth) - 1);
  localparam logic [13:0] WidthMask = RampMax;
  localparam int Shift = ascr_pkg::ASCR_MAX_W - DataWidth;

  ascr_pkg::ascr_state_s q, d;

  // Bank lookup: bit 4 is the hit flag
  function automatic logic [4:0] regIndex(input logic [7:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < ascr_pkg::ASCR_NUM_REGS; i++) begin
      if (ascr_pkg::REG_ADDR[i] == addr) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // Gain on a right-justified twos-complement sample, saturating
  function automatic logic [13:0] applyGain(input logic [13:0] x, input logic [3:0] code);
    logic signed [13:0] xs;
    logic signed [29:0] prod;
    logic signed [29:0] lim;
    logic [3:0] c;
    xs = $signed(x << Shift) >>> Shift;
    c = (code > ascr_pkg::GAIN_MAX_CODE) ? ascr_pkg::GAIN_MAX_CODE : code;
    prod = (30'(xs) * $signed({16'h0000, ascr_pkg::GAIN_Q12[c]})) >>> ascr_pkg::GAIN_FRAC_BITS;
    lim = 30'((1 << (DataWidth - 1)) - 1);
    if (prod > lim) begin
      prod = lim;
    end else if (prod < -lim - 30'sd1) begin
      prod = -lim - 30'sd1;
    end
    return prod[13:0] & WidthMask;
  endfunction

  logic [4:0] rdHit;
  logic [7:0] rdAddr;
  logic [7:0] rdValue;
  logic [4:0] wrHit;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic sclkFall;
  logic sdBit;
  logic digEn;
  logic gainOn;
  logic [2:0] patSel;
  logic [13:0] rawExt;
  logic [13:0] userWord;
  logic [13:0] rampNext;

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    rdAddr = {q.shiftIn[6:0], q.sdataSync[2]};
    wrAddr = q.shiftIn[14:7];
    wrData = {q.shiftIn[6:0], q.sdataSync[2]};
    rdHit = regIndex(rdAddr);
    wrHit = regIndex(wrAddr);
    // Address zero cannot be read back
    rdValue = (rdHit[4] && rdHit[3:0] != 4'h0) ? q.regs[rdHit[3:0]] : 8'h00;
    sdBit = q.sdataSync[2];
    digEn = q.regs[ascr_pkg::IDX_CLKLAT][ascr_pkg::DIGPATH_BIT];
    gainOn = !q.regs[ascr_pkg::IDX_GAIN][ascr_pkg::GAIN_BYPASS_BIT];
    patSel = q.regs[ascr_pkg::IDX_GAIN][ascr_pkg::PATTERN_LSB +: 3];
    rawExt = 14'(convData);
    userWord = {q.regs[ascr_pkg::IDX_UPH], q.regs[ascr_pkg::IDX_UPL][7:2]} >> Shift;
    rampNext = (q.rampCount == RampMax) ? 14'h0000 : q.rampCount + 14'h0001;

    // Three-stage pin synchronisers; a level counts once stages two and three agree
    d.senSync = {q.senSync[1:0], serialIn.sen};
    d.sclkSync = {q.sclkSync[1:0], serialIn.sclk};
    d.sdataSync = {q.sdataSync[1:0], serialIn.sdata};
    if (q.senSync[1] == q.senSync[2]) begin
      d.senF = q.senSync[2];
    end
    if (q.sclkSync[1] == q.sclkSync[2]) begin
      d.sclkF = q.sclkSync[2];
    end
    sclkFall = q.sclkF && (q.sclkSync[1] == q.sclkSync[2]) && !q.sclkSync[2];

    // Software reset takes effect one cycle after its write
    if (q.swResetPend) begin
      for (int i = 0; i < ascr_pkg::ASCR_NUM_REGS; i++) begin
        d.regs[i] = ascr_pkg::REG_RESET_VAL;
      end
      d.swResetPend = 1'b0;
    end

    // Serial frame: address byte then data byte, one bit per SCLK fall
    if (q.senF) begin
      d.bitCount = 5'h00;
      d.readbackBit = 1'b0;
    end else if (sclkFall) begin
      d.shiftIn = {q.shiftIn[14:0], sdBit};
      d.bitCount = q.bitCount + 5'h01;
      if (q.bitCount == ascr_pkg::LAST_ADDR_BIT) begin
        d.readbackBit = rdValue[7];
        d.readShift = {rdValue[6:0], 1'b0};
      end else if (q.bitCount > ascr_pkg::LAST_ADDR_BIT) begin
        d.readbackBit = q.readShift[7];
        d.readShift = {q.readShift[6:0], 1'b0};
      end
      if (q.bitCount == ascr_pkg::LAST_FRAME_BIT) begin
        d.bitCount = 5'h00;
        // Readback mode locks every register except address zero
        if (wrHit[4] && (!q.regs[ascr_pkg::IDX_CTRL][ascr_pkg::READBACK_BIT] || wrHit[3:0] == 4'h0)) begin
          d.regs[wrHit[3:0]] = wrData & ascr_pkg::WRITE_MASK[wrHit[3:0]];
          if (wrHit[3:0] == 4'h0 && wrData[ascr_pkg::SW_RESET_BIT]) begin
            d.swResetPend = 1'b1;
          end
        end
      end
    end

    // Shared pin: over-range or serial readback
    d.pinOut = q.regs[ascr_pkg::IDX_CTRL][ascr_pkg::READBACK_BIT] ? d.readbackBit : overRange;

    // Sample path; patterns and gain only with digital path enabled
    d.dataValid = sampleValid;
    if (sampleValid) begin
      // Phase restarts outside toggle mode, so each run opens on the 0101 word
      d.togglePhase = (patSel == ascr_pkg::PAT_TOGGLE) && !q.togglePhase;
      if (patSel == ascr_pkg::PAT_RAMP && digEn) begin
        // 12-bit variant steps once per four samples
        d.rampDiv = (q.rampDiv == RampDivLast) ? 2'h0 : q.rampDiv + 2'h1;
        if (q.rampDiv == RampDivLast) begin
          d.rampCount = rampNext;
        end
      end else begin
        d.rampDiv = 2'h0;
        d.rampCount = 14'h0000;
      end
      if (!digEn) begin
        d.dataOut = rawExt;
      end else begin
        case (patSel)
          ascr_pkg::PAT_NORMAL: d.dataOut = gainOn ?
            applyGain(rawExt, q.regs[ascr_pkg::IDX_GAIN][ascr_pkg::GAIN_LSB +: 4]) : rawExt;
          ascr_pkg::PAT_ZEROS: d.dataOut = 14'h0000;
          ascr_pkg::PAT_ONES: d.dataOut = WidthMask;
          ascr_pkg::PAT_TOGGLE: d.dataOut = (q.togglePhase ? ~ascr_pkg::ALT_WORD : ascr_pkg::ALT_WORD) & WidthMask;
          ascr_pkg::PAT_RAMP: d.dataOut = q.rampCount;
          ascr_pkg::PAT_USER: d.dataOut = userWord;
          default: d.dataOut = rawExt;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs from flops; configuration decoded from stored fields
  assign overrangeOrReadbackPin = q.pinOut;
  assign outValid = q.dataValid;
  assign outData = q.dataOut[DataWidth-1:0];
  // Swing code is held at default unless both enable bits are set
  assign cfg.swingCode = (q.regs[ascr_pkg::IDX_PDN][ascr_pkg::SWING_EN_LSB +: 2] == 2'h3) ?
    q.regs[ascr_pkg::IDX_SWING][ascr_pkg::SWING_LSB +: 6] : 6'h00;
  assign cfg.performanceBoostOne = q.regs[ascr_pkg::IDX_PERF1][1:0];
  assign cfg.performanceBoostTwo = q.regs[ascr_pkg::IDX_PERF2][0];
  assign cfg.clockDriverDriveLevel = q.regs[ascr_pkg::IDX_DRV][ascr_pkg::CLK_DRIVE_BIT];
  assign cfg.dataDriveLevel = q.regs[ascr_pkg::IDX_DRV][ascr_pkg::DATA_DRIVE_BIT];
  assign cfg.digitalPathEnable = q.regs[ascr_pkg::IDX_CLKLAT][ascr_pkg::DIGPATH_BIT];
  assign cfg.standby = q.regs[ascr_pkg::IDX_CLKLAT][ascr_pkg::STANDBY_BIT];
  assign cfg.powerDownGlobal = q.regs[ascr_pkg::IDX_PDN][ascr_pkg::PDN_GLOBAL_BIT];
  assign cfg.powerDownOutBuf = q.regs[ascr_pkg::IDX_PDN][ascr_pkg::PDN_OBUF_BIT];
  assign cfg.formatOffset = q.regs[ascr_pkg::IDX_FMT];
  assign cfg.ifcClkEdge = q.regs[ascr_pkg::IDX_IFC];
  assign cfg.clkFallCtrl = q.regs[ascr_pkg::IDX_CLKLAT][7:6];
  assign cfg.offsetPedestal = q.regs[ascr_pkg::IDX_PED][7:2];
  assign cfg.offsetLoop = q.regs[ascr_pkg::IDX_OFSLOOP];
  assign cfg.lowSpeed = q.regs[ascr_pkg::IDX_SLOW][0];

  // Checks on the register bank and sample path
  property p_swResetClears;
    @(posedge core_clk) disable iff (!rstn)
      q.swResetPend |=> (q.regs == '0) && !q.swResetPend;
  endproperty
  a_swResetClears: assert property (p_swResetClears) else $error("soft reset left a register set");

  property p_swResetSelfClear;
    @(posedge core_clk) disable iff (!rstn)
      q.regs[0][1] |-> q.swResetPend ##1 !q.regs[0][1];
  endproperty
  a_swResetSelfClear: assert property (p_swResetSelfClear) else $error("reset bit did not self-clear");

  property p_pinOverrange;
    @(posedge core_clk) disable iff (!rstn)
      !q.regs[0][0] |=> overrangeOrReadbackPin == $past(overRange);
  endproperty
  a_pinOverrange: assert property (p_pinOverrange) else $error("pin does not follow over-range");

  property p_pinReadback;
    @(posedge core_clk) disable iff (!rstn)
      q.regs[0][0] |=> overrangeOrReadbackPin == q.readbackBit;
  endproperty
  a_pinReadback: assert property (p_pinReadback) else $error("pin does not show readback bit");

  property p_swingGate;
    @(posedge core_clk) disable iff (!rstn)
      (q.regs[10][1:0] != 2'h3) |-> cfg.swingCode == 6'h00;
  endproperty
  a_swingGate: assert property (p_swingGate) else $error("swing code applied while disabled");

  property p_swingApply;
    @(posedge core_clk) disable iff (!rstn)
      (q.regs[10][1:0] == 2'h3) |-> cfg.swingCode == q.regs[1][7:2];
  endproperty
  a_swingApply: assert property (p_swingApply) else $error("enabled swing code not applied");

  property p_gainBypass;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h0 && !gainOn |=> outData == $past(convData);
  endproperty
  a_gainBypass: assert property (p_gainBypass) else $error("gain applied while bypassed");

  property p_lowLatency;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && !digEn |=> outValid && outData == $past(convData);
  endproperty
  a_lowLatency: assert property (p_lowLatency) else $error("low latency path altered data");

  property p_zeros;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h1 |=> outData == '0;
  endproperty
  a_zeros: assert property (p_zeros) else $error("zero pattern not zero");

  sequence s_toggleTwice;
    (sampleValid && digEn && patSel == 3'h3) ##1 (sampleValid && digEn && patSel == 3'h3);
  endsequence
  property p_toggle;
    @(posedge core_clk) disable iff (!rstn)
      s_toggleTwice |=> outData == ~$past(outData);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle pattern did not invert");

  property p_rampStep;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h4 && q.rampDiv == RampDivLast && q.rampCount != RampMax
        |=> q.rampCount == $past(q.rampCount) + 14'h0001;
  endproperty
  a_rampStep: assert property (p_rampStep) else $error("ramp did not step");

  property p_user;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h5 |=> outData == $past(userWord[DataWidth-1:0]);
  endproperty
  a_user: assert property (p_user) else $error("user pattern not output");

  property p_ones;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h2 |=> outData == '1;
  endproperty
  a_ones: assert property (p_ones) else $error("ones pattern not all ones");

  property p_toggleStart;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h3 && !q.togglePhase
        |=> outData == ascr_pkg::ALT_WORD[DataWidth-1:0];
  endproperty
  a_toggleStart: assert property (p_toggleStart) else $error("toggle run did not open on 0101 word");

  property p_rampHold;
    @(posedge core_clk) disable iff (!rstn)
      sampleValid && digEn && patSel == 3'h4 && q.rampDiv != RampDivLast
        |=> q.rampCount == $past(q.rampCount);
  endproperty
  a_rampHold: assert property (p_rampHold) else $error("ramp stepped between divider ends");

  property p_readbackLock;
    @(posedge core_clk) disable iff (!rstn)
      sclkFall && !q.senF && q.bitCount == 5'h0f && q.regs[0][0] && wrHit[4] && wrHit[3:0] != 4'h0
        && !q.swResetPend |=> q.regs == $past(q.regs);
  endproperty
  a_readbackLock: assert property (p_readbackLock) else $error("write landed during readback");

  property p_fixedZero;
    @(posedge core_clk) disable iff (!rstn)
      (q.regs & ~ascr_pkg::WRITE_MASK) == '0;
  endproperty
  a_fixedZero: assert property (p_fixedZero) else $error("fixed-zero bit stored as one");

  property p_pinIdle;
    @(posedge core_clk) disable iff (!rstn)
      q.regs[0][0] && q.senF |=> !overrangeOrReadbackPin;
  endproperty
  a_pinIdle: assert property (p_pinIdle) else $error("readback pin not low between frames");

  property p_driveLevels;
    @(posedge core_clk) disable iff (!rstn)
      cfg.clockDriverDriveLevel == q.regs[4][1] && cfg.dataDriveLevel == q.regs[4][0];
  endproperty
  a_driveLevels: assert property (p_driveLevels) else $error("driver strength not from its register");

  c_swReset: cover property (@(posedge core_clk) disable iff (!rstn) q.swResetPend);
  c_readback: cover property (@(posedge core_clk) disable iff (!rstn) q.regs[0][0] && sclkFall && q.bitCount == 5'h0f);
  c_rampWrap: cover property (@(posedge core_clk) disable iff (!rstn) q.rampCount == RampMax && sampleValid);
  c_toggle: cover property (@(posedge core_clk) disable iff (!rstn) q.togglePhase && patSel == 3'h3);
  c_lockedWrite: cover property (@(posedge core_clk) disable iff (!rstn)
    q.regs[0][0] && sclkFall && q.bitCount == 5'h0f && wrHit == 5'h14);
endmodule
`default_nettype wire
